// >>> logic/pds_regs.svh
`ifndef PDS_REGS_SVH
`define PDS_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------------
`define PDS_IDX_DUTY_CH3      6'h15
`define PDS_IDX_DUTY_CH4      6'h16
`define PDS_IDX_SLEW_1_TO_8   6'h17
`define PDS_IDX_SLEW_9_TO_12  6'h18

// ----------------------------------------------------------------------------
// Reset values and field layout.
// ----------------------------------------------------------------------------
`define PDS_RST_DUTY          8'h00
`define PDS_RST_SLEW          8'h00
`define PDS_SLEW2_USED_MSB    3
`define PDS_SLEW2_RSVD_LSB    4
`define PDS_SLOW_EDGE         1'b0
`define PDS_FAST_EDGE         1'b1

// ----------------------------------------------------------------------------
// PWM timing: a frame is 255 steps, so a duty code of 8'hff holds the output high.
// ----------------------------------------------------------------------------
`define PDS_PWM_LAST_STEP     8'hfe
`define PDS_PWM_TICK_DIV      8'h04

`endif

// >>> logic/pds_pkg.sv
package pds_pkg;

    typedef logic [7:0] pds_byte_t;

    // Configuration handed to the PWM generators and the gate drive.
    typedef struct packed {
        pds_byte_t   duty_ch3;
        pds_byte_t   duty_ch4;
        logic [11:0] bridge_fast_edge;
    } pds_cfg_t;

    // Avalon-MM request as seen by the slave.
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } pds_avs_req_t;

endpackage : pds_pkg

// >>> logic/pds_duty_slew_regs.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pds_regs.svh"
// Functional notes
// - duty codes are unsigned 8-bit; output high fraction equals code divided by 255.
// - channel 3 duty register is one read/write 8-bit field, reset zero.
// - channel 4 duty register at 0x16, read/write, resets to zero.
// - first slew register at 0x17, reset zero; bit n serves bridge n+1.
// - slew bit clear selects slow edge, set selects fast; reset is slow.
// - second slew register at 0x18, reset zero, readable and writable.
// - second slew bits 3..0 serve bridges 12..9; bits 7..4 reserved, reset zero.
// - channel 3 duty register sits at 0x15, reset zero.
module pds_duty_slew_regs (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // Avalon-MM slave
    input  wire pds_pkg::pds_avs_req_t i_avs,
    output logic [31:0]                o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // Configuration to the PWM generators and gate drive
    output pds_pkg::pds_cfg_t          o_cfg,
    // PWM outputs for channels 3 and 4
    output logic [1:0]                 o_pwm
);
    import pds_pkg::*;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
        reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : reg_hit

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // One wait state per access keeps read data registered; the answer comes
    // in the second cycle of every request, mapped or not.
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        req;
    logic        do_wr;

    assign req               = i_avs.read | i_avs.write;
    assign o_avs_waitrequest = req & ~ack_reg;
    assign do_wr             = i_avs.write & ack_reg & i_avs.byteenable[0];

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    pds_byte_t duty3_reg;
    pds_byte_t duty3_next;
    pds_byte_t duty4_reg;
    pds_byte_t duty4_next;
    pds_byte_t slew1_reg;
    pds_byte_t slew1_next;
    pds_byte_t slew2_reg;
    pds_byte_t slew2_next;

    always_comb begin
        ack_next   = req & ~ack_reg;
        rdata_next = rdata_reg;
        duty3_next = duty3_reg;
        duty4_next = duty4_reg;
        slew1_next = slew1_reg;
        slew2_next = slew2_reg;
        if (i_avs.read && !ack_reg) begin
            rdata_next = 32'h0000_0000;
            if (reg_hit(i_avs.address, `PDS_IDX_DUTY_CH3)) begin
                rdata_next[7:0] = duty3_reg;
            end
            if (reg_hit(i_avs.address, `PDS_IDX_DUTY_CH4)) begin
                rdata_next[7:0] = duty4_reg;
            end
            if (reg_hit(i_avs.address, `PDS_IDX_SLEW_1_TO_8)) begin
                rdata_next[7:0] = slew1_reg;
            end
            if (reg_hit(i_avs.address, `PDS_IDX_SLEW_9_TO_12)) begin
                rdata_next[7:0] = slew2_reg;
            end
        end
        if (do_wr) begin
            if (reg_hit(i_avs.address, `PDS_IDX_DUTY_CH3)) begin
                duty3_next = i_avs.writedata[7:0];
            end
            if (reg_hit(i_avs.address, `PDS_IDX_DUTY_CH4)) begin
                duty4_next = i_avs.writedata[7:0];
            end
            if (reg_hit(i_avs.address, `PDS_IDX_SLEW_1_TO_8)) begin
                slew1_next = i_avs.writedata[7:0];
            end
            if (reg_hit(i_avs.address, `PDS_IDX_SLEW_9_TO_12)) begin
                slew2_next = i_avs.writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            duty3_reg <= `PDS_RST_DUTY;
            duty4_reg <= `PDS_RST_DUTY;
            slew1_reg <= `PDS_RST_SLEW;
            slew2_reg <= `PDS_RST_SLEW;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
            duty3_reg <= duty3_next;
            duty4_reg <= duty4_next;
            slew1_reg <= slew1_next;
            slew2_reg <= slew2_next;
        end
    end

    assign o_avs_readdata = rdata_reg;

    // ------------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------------
    always_comb begin
        o_cfg.duty_ch3 = duty3_reg;
        o_cfg.duty_ch4 = duty4_reg;
        o_cfg.bridge_fast_edge[7:0]  = slew1_reg;
        o_cfg.bridge_fast_edge[11:8] = slew2_reg[`PDS_SLEW2_USED_MSB:0];
    end

    // ------------------------------------------------------------------------
    // PWM step divider and frame counter
    // ------------------------------------------------------------------------
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic [7:0] step_reg;
    logic [7:0] step_next;
    logic       tick;

    assign tick = (div_reg == `PDS_PWM_TICK_DIV - 8'h01);

    always_comb begin
        div_next  = tick ? 8'h00 : div_reg + 8'h01;
        step_next = step_reg;
        if (tick) begin
            step_next = (step_reg == `PDS_PWM_LAST_STEP) ? 8'h00 : step_reg + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg  <= 8'h00;
            step_reg <= 8'h00;
        end else begin
            div_reg  <= div_next;
            step_reg <= step_next;
        end
    end

    // ------------------------------------------------------------------------
    // PWM comparators
    // ------------------------------------------------------------------------
    // A comparison against 0..254 means code 0 never drives high and code 255
    // always does, which is exactly the code/255 scale.
    pds_byte_t duty_sel [2];
    logic [1:0] pwm_reg;
    logic [1:0] pwm_next;

    assign duty_sel[0] = duty3_reg;
    assign duty_sel[1] = duty4_reg;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_pwm
            assign pwm_next[ch] = (step_reg < duty_sel[ch]);
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_reg <= 2'h0;
        end else begin
            pwm_reg <= pwm_next;
        end
    end

    assign o_pwm = pwm_reg;

endmodule : pds_duty_slew_regs

// >>> testbench/pds_regs_asserts.sv
`timescale 1ns/1ps
module pds_regs_chk (
    // Clock and reset
    input wire logic                  i_clk,
    input wire logic                  i_rst_n,
    // Watched ports
    input wire pds_pkg::pds_avs_req_t i_avs,
    input wire logic [31:0]           o_avs_readdata,
    input wire logic                  o_avs_waitrequest,
    input wire pds_pkg::pds_cfg_t     o_cfg,
    input wire logic [1:0]            o_pwm
);
    import pds_pkg::*;
    logic wr_ok;
    // A write counts only on the accepting edge with lane 0 enabled.
    assign wr_ok = i_avs.write && !o_avs_waitrequest && i_avs.byteenable[0];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_duty_ch3: assert property (wr_ok && i_avs.address == 8'h54
        |=> o_cfg.duty_ch3 == $past(i_avs.writedata[7:0])) else $error("duty ch3 not stored");
    a_duty_ch4: assert property (wr_ok && i_avs.address == 8'h58
        |=> o_cfg.duty_ch4 == $past(i_avs.writedata[7:0])) else $error("duty ch4 not stored");
    a_slew_low: assert property (wr_ok && i_avs.address == 8'h5c
        |=> o_cfg.bridge_fast_edge[7:0] == $past(i_avs.writedata[7:0]))
        else $error("slew low byte not stored");
    a_slew_high: assert property (wr_ok && i_avs.address == 8'h60
        |=> o_cfg.bridge_fast_edge[11:8] == $past(i_avs.writedata[3:0]))
        else $error("slew high nibble not stored");
    a_cfg_hold: assert property (!wr_ok |=> $stable(o_cfg))
        else $error("config changed without write");
    a_read_upper: assert property (i_avs.read && !o_avs_waitrequest
        |-> o_avs_readdata[31:8] == 24'h0) else $error("read upper bits not zero");
    a_wait_once: assert property ($rose(i_avs.read || i_avs.write)
        |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait state count wrong");
    a_pwm_zero: assert property ($past(o_cfg.duty_ch3) == 8'h00 |-> !o_pwm[0])
        else $error("pwm high at zero duty");
    a_pwm_full: assert property ($past(o_cfg.duty_ch4) == 8'hff |-> o_pwm[1])
        else $error("pwm low at full duty");
endmodule : pds_regs_chk

bind pds_duty_slew_regs pds_regs_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(i_avs),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_cfg(o_cfg), .o_pwm(o_pwm));

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pds_pkg::*;
    logic         i_clk;
    logic         i_rst_n;
    pds_avs_req_t req;
    logic [31:0]  rdata;
    logic         wreq;
    pds_cfg_t     cfg;
    logic [1:0]   pwm;
    int           err_total;
    int           checked;
    logic [31:0]  q;
    int           c0;
    int           c1;
    logic [7:0]   adr [4] = '{8'h54, 8'h58, 8'h5c, 8'h60};
    logic [7:0]   dv [4]  = '{8'h80, 8'hff, 8'h81, 8'ha5};

    pds_duty_slew_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(req),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_cfg(cfg), .o_pwm(pwm));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // The request is held until a rising edge samples waitrequest low; it is released there.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] r);
        int n;
        @(posedge i_clk);
        req <= '{a, !w, w, be, d};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0) begin
            err_total++;
            tally_and_finish();
        end
        r = rdata;
        req <= '0;
    endtask : bus

    task automatic pwm_count;
        c0 = 0;
        c1 = 0;
        repeat (4) @(negedge i_clk);
        repeat (1020) begin
            @(negedge i_clk);
            c0 += (pwm[0] === 1'b1);
            c1 += (pwm[1] === 1'b1);
        end
    endtask : pwm_count

    initial begin
        err_total = 0;
        checked = 0;
        req = '0;
        i_rst_n = 1'b0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(adr[i], 1'b0, 32'h0, 4'h0, q);
            chk(q, 32'h0); // Reset value
        end
        for (int i = 0; i < 4; i++) bus(adr[i], 1'b1, {24'hffffff, dv[i]}, 4'hf, q);
        for (int i = 0; i < 4; i++) begin
            bus(adr[i], 1'b0, 32'h0, 4'h0, q);
            chk(q, {24'h0, dv[i]}); // Readback
        end
        chk({4'h0, cfg}, {4'h0, 8'h80, 8'hff, 12'h581}); // Bridge bit order
        bus(8'h58, 1'b1, 32'h11, 4'h0, q);
        bus(8'h64, 1'b1, 32'h22, 4'hf, q);
        bus(8'h59, 1'b1, 32'h33, 4'hf, q);
        bus(8'h64, 1'b0, 32'h0, 4'h0, q);
        chk(q, 32'h0); // Unmapped read
        bus(8'h58, 1'b0, 32'h0, 4'h0, q);
        chk(q, 32'hff); // Ignored writes
        pwm_count();
        chk(c0, 512); // Half duty
        chk(c1, 1020); // Full duty
        bus(8'h54, 1'b1, 32'h0, 4'h1, q);
        bus(8'h58, 1'b1, 32'h1, 4'h1, q);
        pwm_count();
        chk(c0, 0); // Zero duty
        chk(c1, 4); // One step
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(negedge i_clk);
        chk({4'h0, cfg}, 32'h0); // Mid-run reset
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        bus(8'h5c, 1'b0, 32'h0, 4'h0, q);
        chk(q, 32'h0); // Slew reset after release
        tally_and_finish();
    end
endmodule : testbench
